/* File: bench/das_link_sva.sv */
// assertions on the link between host and device ends
`timescale 1ns/1ns
module das_link_sva import das_pkg::*; (
  input wire logic       mclk,
  input wire logic       arst_n,
  input wire logic       idBitValid,
  input wire logic       idBit,
  input wire logic       idLast,
  input wire logic       idReq,
  input wire logic       saddrWrite,
  input wire logic [7:0] saddrWdata,
  input wire logic       srcWrite,
  input wire das_src_t   srcWdata,
  input wire logic       shutdown,
  input wire logic [7:0] saddr,
  input wire logic       decodeBusy
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  das_src_t   mode_q;
  logic [5:0] bitCnt_q;
  // mirror of the source select; only moves through 00b are taken
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      mode_q <= DAS_SRC_STORED;
    end else if (srcWrite && !decodeBusy
                 && (mode_q == DAS_SRC_STORED || srcWdata == DAS_SRC_STORED)) begin
      mode_q <= srcWdata;
    end
  end
  // wraps at 64, so a whole read leaves it at zero
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      bitCnt_q <= 6'h00;
    end else if (idBitValid) begin
      bitCnt_q <= bitCnt_q + 6'h01;
    end
  end
  AST_ID_START: assert property ($rose(idReq) |-> ##2 idBitValid [*8])
    else $error("identifier bits late after request");
  AST_ID_LAST: assert property (idLast |-> idBitValid && bitCnt_q == 6'h3f)
    else $error("last identifier bit not the 64th");
  AST_SADDR_TAKE: assert property (saddrWrite && mode_q == DAS_SRC_STORED
    |=> saddr == $past(saddrWdata)) else $error("short address write not taken");
  AST_SADDR_REFUSE: assert property (saddrWrite && mode_q == DAS_SRC_RES && !shutdown
    |=> $stable(saddr)) else $error("short address write taken in strap mode");
  AST_BUSY_RISE: assert property ($rose(shutdown) && mode_q[1] |=> decodeBusy)
    else $error("decode did not start on shutdown");
  AST_BUSY_BOUND: assert property ($rose(decodeBusy) |-> ##[1:40] !decodeBusy)
    else $error("decode did not finish");
  AST_KEEP_TOP: assert property (decodeBusy |=> saddr[7:6] == $past(saddr[7:6]))
    else $error("stored top bits lost in decode");
  AST_KEEP_NIB: assert property (decodeBusy && mode_q == DAS_SRC_RES
    |=> saddr[7:4] == $past(saddr[7:4])) else $error("upper nibble lost in decode");
  AST_PIN_KEEP: assert property (srcWrite && !decodeBusy && mode_q == DAS_SRC_STORED
    && srcWdata == DAS_SRC_PINS |-> ##2 saddr[7:4] == $past(saddr[7:4], 2))
    else $error("upper nibble lost in pin mode");
endmodule : das_link_sva

/* File: bench/tb.sv */
// self-checking bench: host and device ends joined over the link
`timescale 1ns/1ns
module tb;
  import das_pkg::*;
  localparam logic [7:0]  FAM = 8'h3c;              // arbitrary value
  localparam logic [47:0] SER = 48'h9e37_5a21_c0d4; // arbitrary value
  logic        mclk = 1'b0;
  logic        arst_n, clkEn, nvValid, readIdStart, saddrWrStart, srcWrStart, shutdownReq;
  logic        resGrounded, resFloating, idDone, idCrcOk, nvSaveReq;
  logic [7:0]  nvSaddr, saddrWrData, saddrSeen;
  logic [3:0]  gpPinIn, gpPinIsOut, resistorCodeBit;
  logic [63:0] idValue, idWire, expId;
  das_src_t    srcWrData;
  int          bitCnt, fail_count = 0, samples_checked = 0;
  das_link_if link ();
  das_device #(.FAMILY_CODE(FAM), .SERIAL_NUM(SER), .DETECT_CYC(4)) i_das_device (.mclk,
    .arst_n, .clkEn, .nvSaddr, .nvValid, .gpPinIn, .gpPinIsOut, .resGrounded, .resFloating,
    .resistorCodeBit, .link);
  das_host i_das_host (.mclk, .arst_n, .clkEn, .readIdStart, .saddrWrStart, .saddrWrData,
    .srcWrStart, .srcWrData, .shutdownReq, .idValue, .idDone, .idCrcOk, .saddrSeen,
    .nvSaveReq, .link);
  das_link_sva i_das_link_sva (.mclk, .arst_n, .idBitValid(link.idBitValid),
    .idBit(link.idBit), .idLast(link.idLast), .idReq(link.idReq),
    .saddrWrite(link.saddrWrite), .saddrWdata(link.saddrWdata), .srcWrite(link.srcWrite),
    .srcWdata(link.srcWdata), .shutdown(link.shutdown), .saddr(link.saddr),
    .decodeBusy(link.decodeBusy));
  initial forever #5 mclk = ~mclk;
  // shift in from the top, so bit 0 sent first lands at index 0
  always @(posedge mclk) begin
    if (link.idBitValid === 1'b1) begin
      idWire <= {link.idBit, idWire[63:1]};
      bitCnt <= bitCnt + 1;
    end
  end
  function automatic logic [7:0] crc8(input logic [55:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 0; i < 56; i++) begin
      c = (c >> 1) ^ ((c[0] ^ d[i]) ? 8'h8c : 8'h00);
    end
    return c;
  endfunction : crc8
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic summarize();
    $display("checks=%0d mismatches=%0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : summarize
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask : cyc
  task automatic wr(input logic [7:0] v);
    saddrWrData = v;
    saddrWrStart = 1'b1;
    cyc(1);
    saddrWrStart = 1'b0;
    cyc(3);
  endtask : wr
  task automatic src(input das_src_t m);
    srcWrData = m;
    srcWrStart = 1'b1;
    cyc(1);
    srcWrStart = 1'b0;
    cyc(5);
  endtask : src
  task automatic t_restore();
    cyc(3);
    arst_n = 1'b1;
    cyc(3);
    chk(link.saddr, 8'ha5);
    chk(saddrSeen, 8'ha5);
  endtask : t_restore
  task automatic t_read_id();
    int n;
    n = 0;
    bitCnt = 0;
    readIdStart = 1'b1;
    cyc(1);
    readIdStart = 1'b0;
    while (idDone !== 1'b1 && n < 200) begin
      cyc(1);
      n++;
    end
    chk(idDone, 1'b1);
    chk(idWire, expId);
    chk(bitCnt, 64);
    chk(idValue, expId);
    chk(idCrcOk, 1'b1);
  endtask : t_read_id
  task automatic t_pins();
    wr(8'hc3);
    chk(link.saddr, 8'hc3);
    gpPinIn = 4'hb;
    gpPinIsOut = 4'h2;
    src(DAS_SRC_PINS);
    chk(link.saddr, 8'hc9);
    gpPinIn = 4'h0;
    wr(8'h11);
    chk(link.saddr, 8'hc9);
    src(DAS_SRC_STORED);
  endtask : t_pins
  task automatic t_res(input das_src_t m, input logic g, input logic f, input logic [3:0] code,
                       input logic [7:0] exp);
    int n, saves;
    logic seen;
    {n, saves, seen} = '0;
    wr(8'hc3);
    gpPinIsOut = 4'h0;
    {gpPinIn, resGrounded, resFloating, resistorCodeBit} = {4'hb, g, f, code};
    src(m);
    wr(8'h5a);
    shutdownReq = 1'b1;
    while (n < 60 && !(seen && link.decodeBusy === 1'b0)) begin
      cyc(1);
      n++;
      seen |= link.decodeBusy === 1'b1;
      saves += int'(nvSaveReq === 1'b1);
    end
    repeat (3) begin
      cyc(1);
      saves += int'(nvSaveReq === 1'b1);
    end
    shutdownReq = 1'b0;
    chk(seen, 1'b1);
    chk(link.saddr, exp);
    chk(saddrSeen, exp);
    chk(saves, 1);
    src(DAS_SRC_STORED);
  endtask : t_res
  initial begin
    {arst_n, readIdStart, saddrWrStart, srcWrStart, shutdownReq, resGrounded} = '0;
    {resFloating, saddrWrData, gpPinIn, gpPinIsOut, resistorCodeBit} = '0;
    {clkEn, nvValid, nvSaddr} = {2'b11, 8'ha5};
    srcWrData = DAS_SRC_STORED;
    expId = {crc8({SER, FAM}), SER, FAM};
    t_restore();
    t_read_id();
    t_pins();
    t_res(DAS_SRC_RES, 1'b1, 1'b0, 4'h7, 8'hc0);
    t_res(DAS_SRC_RES, 1'b0, 1'b1, 4'h2, 8'hcf);
    t_res(DAS_SRC_RES, 1'b0, 1'b0, 4'h6, 8'hc6);
    t_res(DAS_SRC_BOTH, 1'b0, 1'b0, 4'ha, 8'hfa);
    t_read_id();
    summarize();
  end
  // whole run needs a few hundred cycles at most
  initial begin
    #100000;
    fail_count++;
    summarize();
  end
endmodule : tb

/* File: logic/das_device.sv */
// device end: fixed identifier, serial readout and short address select
`timescale 1ns/1ns
// Contract
// - identifier fixed at build, never writable
// - identifier sent bit 0 first to 63
// - bits 7:0 hold family code
// - 48-bit serial then checksum over 56 bits
// - short address writable only in source 00b
// - leaving 00b decodes straps onto short address
// - host saves short address to nonvolatile memory
// - restored short address loaded at power-up
// - pin mode: bits 3:0 from pins 3:0
// - pin mode entered from 00b, pins latched
// - host makes pins inputs before strap modes
// - output-configured pin latches as zero
// - resistor mode: bits 3:0 resistor code
// - short address eight bits wide
// - resistor mode: shutdown, idle for detect time
// - combined: resistor 3:0, pins 1:0 at 5:4
// - grounded gives 0000b, floating gives 1111b
// - checksum reflected 0x31, seed 00h, lsb first
module das_device import das_pkg::*; #(
  parameter logic [7:0]  FAMILY_CODE  = 8'h5a,         // arbitrary value
  parameter logic [47:0] SERIAL_NUM   = 48'h0123_4567_89ab, // arbitrary value
  parameter int          DETECT_CYC   = RES_DETECT_CYC
) (
  input  wire logic       mclk,
  input  wire logic       arst_n,
  input  wire logic       clkEn,
  input  wire logic [7:0] nvSaddr,
  input  wire logic       nvValid,
  input  wire logic [3:0] gpPinIn,
  input  wire logic [3:0] gpPinIsOut,
  input  wire logic       resGrounded,
  input  wire logic       resFloating,
  input  wire logic [3:0] resistorCodeBit,
  das_link_if.dev         link
);
  // refuse settings the counters cannot serve
  if (DETECT_CYC < 1) begin : g_bad_detect
    $error("DETECT_CYC must be at least one");
  end
  if (ID_CNT_W < $clog2(ID_W)) begin : g_bad_idcnt
    $error("identifier bit counter too narrow");
  end

  // reflected checksum, lsb first, no final inversion
  function automatic logic [7:0] crc8(input logic [55:0] data);
    logic [7:0] c;
    c = CRC_SEED;
    for (int i = 0; i < 56; i++) begin
      if (c[0] ^ data[i]) c = (c >> 1) ^ CRC_POLY_REFL;
      else c = c >> 1;
    end
    return c;
  endfunction : crc8

  // constant identifier: no write path exists at all
  localparam logic [55:0] ID_LOW = {SERIAL_NUM, FAMILY_CODE};
  localparam logic [63:0] ID_VAL = {crc8(ID_LOW), ID_LOW};
  // detect counter sized from the parameter, not the package default
  localparam int               DET_W    = $clog2(DETECT_CYC + 1);
  localparam logic [DET_W-1:0] DET_LOAD = DET_W'(DETECT_CYC);
  localparam logic [DET_W-1:0] DET_ONE  = DET_W'(1);

  das_state_t         state_q;
  logic [ID_CNT_W-1:0] bitIdx_q;
  logic               idBitValid_q;
  logic               idBit_q;
  logic               idLast_q;
  logic [7:0]         saddr_q;
  das_src_t           src_q;
  logic [3:0]         pinLatch_q;
  logic               pinsPend_q;
  logic               resPend_q;
  logic [DET_W-1:0]   detCnt_q;
  logic               decodeBusy_q;
  logic               nvDone_q;
  logic [3:0]         pinMasked;
  logic [3:0]         resCode;
  logic               detDone;

  // a pin driven as output reads as zero, never its own drive level
  for (genvar b = 0; b < 4; b++) begin : g_pin_mask
    assign pinMasked[b] = gpPinIn[b] & ~gpPinIsOut[b];
  end

  // last detect cycle still shut down: the only moment the code is taken
  assign detDone = decodeBusy_q && link.shutdown && (detCnt_q == DET_ONE);
  always_comb begin
    if (resGrounded) resCode = RES_CODE_GND;
    else if (resFloating) resCode = RES_CODE_FLOAT;
    else resCode = resistorCodeBit;
  end

  // identifier serialiser
  // one request gives one readout; idReq must drop before the next
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state_q      <= DAS_IDLE;
      bitIdx_q     <= '0;
      idBitValid_q <= 1'b0;
      idBit_q      <= 1'b0;
      idLast_q     <= 1'b0;
    end else if (clkEn) begin
      idBitValid_q <= 1'b0;
      idLast_q     <= 1'b0;
      unique case (state_q)
        DAS_IDLE: begin
          if (link.idReq) begin
            state_q  <= DAS_SEND;
            bitIdx_q <= '0;
          end
        end
        DAS_SEND: begin
          idBitValid_q <= 1'b1;
          idBit_q      <= ID_VAL[bitIdx_q];
          idLast_q     <= (bitIdx_q == ID_CNT_W'(ID_W-1));
          bitIdx_q     <= bitIdx_q + 1'b1;
          if (bitIdx_q == ID_CNT_W'(ID_W-1)) state_q <= DAS_WAIT;
        end
        DAS_WAIT: begin
          if (!link.idReq) state_q <= DAS_IDLE;
        end
        default: state_q <= DAS_IDLE;
      endcase
    end
  end

  // source select and strap latching
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      src_q      <= DAS_SRC_STORED;
      pinLatch_q <= '0;
      pinsPend_q <= 1'b0;
      resPend_q  <= 1'b0;
    end else if (clkEn) begin
      pinsPend_q <= 1'b0;
      // refused mid-decode, so a running decode is never cut short
      if (link.srcWrite && !decodeBusy_q) begin
        // a new strap mode is accepted only from the stored mode
        if (src_q == DAS_SRC_STORED || link.srcWdata == DAS_SRC_STORED) begin
          src_q <= link.srcWdata;
          // back to stored mode drops a decode still waiting for shutdown
          if (link.srcWdata == DAS_SRC_STORED) resPend_q <= 1'b0;
          if (src_q == DAS_SRC_STORED && link.srcWdata != DAS_SRC_STORED) begin
            pinLatch_q <= pinMasked;
            pinsPend_q <= (link.srcWdata == DAS_SRC_PINS);
            resPend_q  <= (link.srcWdata != DAS_SRC_PINS);
          end
        end
      end
      if (detDone) resPend_q <= 1'b0;
    end
  end

  // resistor detect timer, runs only while shut down and idle
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      detCnt_q     <= '0;
      decodeBusy_q <= 1'b0;
    end else if (clkEn) begin
      if (resPend_q && !decodeBusy_q && link.shutdown) begin
        decodeBusy_q <= 1'b1;
        detCnt_q     <= DET_LOAD;
      end else if (decodeBusy_q) begin
        if (!link.shutdown) begin
          detCnt_q <= DET_LOAD; // restart on early wake
        end else if (detCnt_q == DET_ONE) begin
          decodeBusy_q <= 1'b0;
          detCnt_q     <= '0;
        end else begin
          detCnt_q <= detCnt_q - 1'b1;
        end
      end
    end
  end

  // short address register
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      saddr_q  <= SADDR_RST;
      nvDone_q <= 1'b0;
    end else if (clkEn) begin
      // restore wins once, so no early host write can beat it
      if (!nvDone_q && nvValid) begin
        saddr_q  <= nvSaddr;
        nvDone_q <= 1'b1;
      end else if (link.saddrWrite && src_q == DAS_SRC_STORED) begin
        saddr_q <= link.saddrWdata;
      end else if (pinsPend_q) begin
        // only the strap nibble is overlaid; stored upper bits stay
        saddr_q[3:0] <= pinLatch_q;
      end else if (detDone) begin
        saddr_q[3:0] <= resCode;
        if (src_q == DAS_SRC_BOTH) saddr_q[5:4] <= pinLatch_q[1:0];
      end
    end
  end

  // every link output straight from a flop
  assign link.idBitValid = idBitValid_q;
  assign link.idBit      = idBit_q;
  assign link.idLast     = idLast_q;
  assign link.saddr      = saddr_q;
  assign link.decodeBusy = decodeBusy_q;
endmodule : das_device

/* File: logic/das_host.sv */
// host end: collects identifier, writes short address and source select
`timescale 1ns/1ns
module das_host import das_pkg::*; (
  input  wire logic       mclk,
  input  wire logic       arst_n,
  input  wire logic       clkEn,
  input  wire logic       readIdStart,
  input  wire logic       saddrWrStart,
  input  wire logic [7:0] saddrWrData,
  input  wire logic       srcWrStart,
  input  wire das_src_t   srcWrData,
  input  wire logic       shutdownReq,
  output      logic [63:0] idValue,
  output      logic       idDone,
  output      logic       idCrcOk,
  output      logic [7:0] saddrSeen,
  output      logic       nvSaveReq,
  das_link_if.host        link
);
  logic        idReq_q;
  logic [63:0] idShift_q;
  logic        idDone_q;
  logic        idCrcOk_q;
  logic        saddrWrite_q;
  logic [7:0]  saddrWdata_q;
  logic        srcWrite_q;
  das_src_t    srcWdata_q;
  logic        shutdown_q;
  logic [7:0]  saddrSeen_q;
  logic        nvSave_q;
  logic        busyPrev_q;
  logic [63:0] idNext;
  logic [7:0]  crcAll;

  assign idNext = {link.idBit, idShift_q[63:1]};

  always_comb begin
    crcAll = CRC_SEED;
    for (int i = 0; i < 64; i++) begin
      if (crcAll[0] ^ idNext[i]) crcAll = (crcAll >> 1) ^ CRC_POLY_REFL;
      else crcAll = crcAll >> 1;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      idReq_q   <= 1'b0;
      idShift_q <= '0;
      idDone_q  <= 1'b0;
      idCrcOk_q <= 1'b0;
    end else if (clkEn) begin
      idDone_q <= 1'b0;
      if (readIdStart && !idReq_q) idReq_q <= 1'b1;
      if (link.idBitValid) begin
        idShift_q <= idNext;
        if (link.idLast) begin
          idReq_q   <= 1'b0;
          idDone_q  <= 1'b1;
          idCrcOk_q <= (crcAll == 8'h00); // residue zero when intact
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      saddrWrite_q <= 1'b0;
      saddrWdata_q <= '0;
      srcWrite_q   <= 1'b0;
      srcWdata_q   <= DAS_SRC_STORED;
      shutdown_q   <= 1'b0;
    end else if (clkEn) begin
      saddrWrite_q <= saddrWrStart;
      if (saddrWrStart) saddrWdata_q <= saddrWrData;
      srcWrite_q <= srcWrStart;
      if (srcWrStart) srcWdata_q <= srcWrData;
      shutdown_q <= shutdownReq;
    end
  end

  // after a decode ends, ask for the address to be saved
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      saddrSeen_q <= '0;
      nvSave_q    <= 1'b0;
      busyPrev_q  <= 1'b0;
    end else if (clkEn) begin
      saddrSeen_q <= link.saddr;
      busyPrev_q  <= link.decodeBusy;
      nvSave_q    <= busyPrev_q && !link.decodeBusy;
    end
  end

  assign link.idReq      = idReq_q;
  assign link.saddrWrite = saddrWrite_q;
  assign link.saddrWdata = saddrWdata_q;
  assign link.srcWrite   = srcWrite_q;
  assign link.srcWdata   = srcWdata_q;
  assign link.shutdown   = shutdown_q;
  assign idValue   = idShift_q;
  assign idDone    = idDone_q;
  assign idCrcOk   = idCrcOk_q;
  assign saddrSeen = saddrSeen_q;
  assign nvSaveReq = nvSave_q;
endmodule : das_host

/* File: logic/das_link_if.sv */
// link between the address select device end and its host controller
`timescale 1ns/1ns
interface das_link_if;
  import das_pkg::*;
  logic             idBitValid;
  logic             idBit;
  logic             idLast;
  logic             idReq;
  logic             saddrWrite;
  logic [7:0]       saddrWdata;
  logic             srcWrite;
  das_src_t         srcWdata;
  logic             shutdown;
  logic [7:0]       saddr;
  logic             decodeBusy;
  modport dev  (input idReq, saddrWrite, saddrWdata, srcWrite, srcWdata, shutdown,
                output idBitValid, idBit, idLast, saddr, decodeBusy);
  modport host (output idReq, saddrWrite, saddrWdata, srcWrite, srcWdata, shutdown,
                input idBitValid, idBit, idLast, saddr, decodeBusy);
endinterface : das_link_if

/* File: logic/das_pkg.sv */
// shared constants and types for the device address select block
package das_pkg;
  localparam int ID_W          = 64;
  localparam int SADDR_W       = 8;
  localparam int FAMILY_LSB    = 0;
  localparam int FAMILY_W      = 8;
  localparam int SERIAL_LSB    = 8;
  localparam int SERIAL_W      = 48;
  localparam int CRC_LSB       = 56;
  localparam int CRC_W         = 8;
  localparam logic [7:0] CRC_POLY_REFL = 8'h8c;
  localparam logic [7:0] CRC_SEED      = 8'h00;
  localparam logic [7:0] SADDR_RST     = 8'h00;
  localparam int NIB_LSB       = 0;
  localparam int GPIO_HI_LSB   = 4;
  localparam int KEEP_LSB      = 6;
  localparam logic [3:0] RES_CODE_GND   = 4'h0;
  localparam logic [3:0] RES_CODE_FLOAT = 4'hf;
  localparam int RES_DETECT_US  = 10;
  localparam int CLK_MHZ        = 100;
  localparam int RES_DETECT_CYC = RES_DETECT_US * CLK_MHZ;
  localparam int ID_CNT_W       = 6;

  typedef enum logic [1:0] {
    DAS_SRC_STORED = 2'b00,
    DAS_SRC_PINS   = 2'b01,
    DAS_SRC_RES    = 2'b10,
    DAS_SRC_BOTH   = 2'b11
  } das_src_t;

  typedef enum logic [1:0] {
    DAS_IDLE = 2'b00,
    DAS_SEND = 2'b01,
    DAS_WAIT = 2'b10
  } das_state_t;
endpackage : das_pkg
